// [ossr_startup_top.sv]
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module ossr_startup_top import ossr_pkg::*; #(
  parameter int TOUT_LONG_CYC = OSSR_TOUT_LONG_CYC
) (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Fuse array and reset sources
  input wire logic [3:0] CLOCK_SOURCE_SELECT_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic DIVIDE_BY_EIGHT_FUSE,
  input wire logic RESET_SOURCES_RELEASED,
  input wire logic BROWNOUT_DETECTOR_OK,
  // Sleep control
  input wire logic SLEEP_ENTER,
  input wire logic WAKE_UP,
  // Oscillator samples
  input wire logic OSC_CLK,
  input wire logic WDT_OSC_CLK,
  // Core side
  output logic CORE_RESET_N,
  output logic CLOCK_STABLE,
  output logic SYSCLK_EN,
  output logic [2:0] FREQ_RANGE
);

  localparam logic [15:0] TOUT_SHORT_W = 16'(OSSR_TOUT_SHORT_CYC);
  localparam logic [15:0] TOUT_LONG_W = 16'(TOUT_LONG_CYC);

  ossr_state_t state_q, state_d;
  ossr_fuse_t fuse_q;
  ossr_decode_t dec;
  logic fuse_loaded_q;
  logic [1:0] ctrl_q;
  logic restart_q;
  logic osc_q, wdt_q;
  logic osc_tick, wdt_tick;
  logic phase_clr;
  logic [15:0] osc_target, tout_target;
  logic [15:0] osc_count, wdt_count;
  logic osc_done, wdt_done;
  logic [2:0] div_q;
  logic bod_en;
  logic unguarded;
  logic core_reset_n_q, clock_stable_q, sysclk_en_q;
  logic [2:0] range_q;
  logic addr_ok;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q;

  // Oscillator inputs are sampled on CLK, so each rising sample is one
  // oscillator cycle; an oscillator above half of CLK would be undercounted.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_q <= 1'b0;
      wdt_q <= 1'b0;
    end else if (CE) begin
      osc_q <= OSC_CLK;
      wdt_q <= WDT_OSC_CLK;
    end
  end

  assign osc_tick = OSC_CLK & ~osc_q;
  assign wdt_tick = WDT_OSC_CLK & ~wdt_q;

  // Fuse shadow: loaded from the pins after reset release, writable later.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fuse_q <= '1;
      fuse_loaded_q <= 1'b0;
    end else if (CE) begin
      if (!fuse_loaded_q) begin
        fuse_q.clock_source_select_fuses <= CLOCK_SOURCE_SELECT_FUSES;
        fuse_q.startup_time_fuses <= STARTUP_TIME_FUSES;
        fuse_q.divide_by_eight_fuse <= DIVIDE_BY_EIGHT_FUSE;
        fuse_loaded_q <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == OSSR_FUSE_OFS) begin
        fuse_q <= HWDATA[OSSR_FUSE_DIV_BIT:OSSR_FUSE_SEL_LSB];
      end
    end
  end

  // Fuse codes below are the raw fuse levels, 0 meaning programmed.
  always_comb begin
    dec.low_power = 1'b0;
    dec.range = fuse_q.clock_source_select_fuses[3:1];
    dec.settle = OSSR_SETTLE_6;
    dec.tout = OSSR_TOUT_LONG;
    case (fuse_q.startup_time_fuses)
      2'h0: dec.tout = OSSR_TOUT_NONE;
      2'h1: dec.tout = OSSR_TOUT_SHORT;
      default: dec.tout = OSSR_TOUT_LONG;
    endcase
    if (fuse_q.clock_source_select_fuses[3]) begin
      dec.low_power = 1'b1;
      // The settling 258-cycle codes suit resonators only.
      case ({fuse_q.clock_source_select_fuses[0],
             fuse_q.startup_time_fuses})
        3'h0: begin
          dec.settle = OSSR_SETTLE_258;
          dec.tout = OSSR_TOUT_SHORT;
        end
        3'h1: begin
          dec.settle = OSSR_SETTLE_258;
          dec.tout = OSSR_TOUT_LONG;
        end
        3'h2: begin
          dec.settle = OSSR_SETTLE_1K;
          dec.tout = OSSR_TOUT_NONE;
        end
        3'h3: begin
          dec.settle = OSSR_SETTLE_1K;
          dec.tout = OSSR_TOUT_SHORT;
        end
        3'h4: begin
          dec.settle = OSSR_SETTLE_1K;
          dec.tout = OSSR_TOUT_LONG;
        end
        3'h5: begin
          dec.settle = OSSR_SETTLE_16K;
          dec.tout = OSSR_TOUT_NONE;
        end
        3'h6: begin
          dec.settle = OSSR_SETTLE_16K;
          dec.tout = OSSR_TOUT_SHORT;
        end
        default: begin
          dec.settle = OSSR_SETTLE_16K;
          dec.tout = OSSR_TOUT_LONG;
        end
      endcase
    end else if (fuse_q.clock_source_select_fuses[3:1] == 3'h2) begin
      // Low-frequency crystal: the longest settling count (32K) when bit 0 is set, else 1K.
      dec.settle = fuse_q.clock_source_select_fuses[0] ?
                   OSSR_SETTLE_32K : OSSR_SETTLE_1K;
    end else begin
      dec.settle = OSSR_SETTLE_6;
    end
  end

  // Time-out length in watchdog cycles, never a supply measurement.
  always_comb begin
    case (dec.tout)
      OSSR_TOUT_SHORT: tout_target = TOUT_SHORT_W;
      OSSR_TOUT_LONG: tout_target = TOUT_LONG_W;
      default: tout_target = 16'h0000;
    endcase
  end

  assign bod_en = ctrl_q[OSSR_CTRL_BOD_EN_BIT];
  assign unguarded = (dec.tout == OSSR_TOUT_NONE) && !bod_en;
  assign osc_target = (state_q == OSSR_S_FIX) ? OSSR_FIXED_19 : dec.settle;
  assign phase_clr = (state_d != state_q);

  ossr_tick_counter #(.W(16)) u_wdt_count (
    .clk(CLK),
    .rst_n(RSTN),
    .ce(CE),
    .clear(phase_clr),
    .tick(wdt_tick),
    .target(tout_target),
    .count(wdt_count),
    .done(wdt_done)
  );

  ossr_tick_counter #(.W(16)) u_osc_count (
    .clk(CLK),
    .rst_n(RSTN),
    .ce(CE),
    .clear(phase_clr),
    .tick(osc_tick),
    .target(osc_target),
    .count(osc_count),
    .done(osc_done)
  );

  // Sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      OSSR_S_HOLD: begin
        if (fuse_loaded_q) begin
          state_d = OSSR_S_TOUT;
        end
      end
      OSSR_S_TOUT: begin
        // A zero time-out with brown-out enabled waits for supply good.
        if (wdt_done && (!bod_en || BROWNOUT_DETECTOR_OK)) begin
          state_d = OSSR_S_FIX;
        end
      end
      OSSR_S_FIX: begin
        if (osc_done) begin
          state_d = OSSR_S_SETTLE;
        end
      end
      OSSR_S_SETTLE: begin
        if (osc_done) begin
          state_d = OSSR_S_RUN;
        end
      end
      OSSR_S_RUN: begin
        if (SLEEP_ENTER) begin
          state_d = OSSR_S_SLEEP;
        end
      end
      OSSR_S_SLEEP: begin
        if (WAKE_UP) begin
          state_d = OSSR_S_SETTLE;
        end
      end
      default: state_d = OSSR_S_HOLD;
    endcase
    if (!RESET_SOURCES_RELEASED || restart_q) begin
      state_d = OSSR_S_HOLD;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= OSSR_S_HOLD;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Core outputs. Reset stays high (released) through a wake; only CLOCK_STABLE drops.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      core_reset_n_q <= 1'b0;
      clock_stable_q <= 1'b0;
      range_q <= 3'h0;
    end else if (CE) begin
      core_reset_n_q <= (state_d == OSSR_S_RUN) ||
                        (state_d == OSSR_S_SLEEP) ||
                        (state_d == OSSR_S_SETTLE &&
                         core_reset_n_q);
      clock_stable_q <= (state_d == OSSR_S_RUN);
      range_q <= dec.range;
    end
  end

  // System clock enable: every oscillator cycle, or every eighth.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      div_q <= OSSR_DIV_RESET;
      sysclk_en_q <= 1'b0;
    end else if (CE) begin
      if (fuse_q.divide_by_eight_fuse == OSSR_FUSE_PROGRAMMED) begin
        if (osc_tick) begin
          div_q <= div_q + 3'h1;
        end
        sysclk_en_q <= osc_tick && (div_q == OSSR_DIV_LAST);
      end else begin
        div_q <= OSSR_DIV_RESET;
        sysclk_en_q <= osc_tick;
      end
    end
  end

  // Bus slave: zero wait states, always OKAY.
  assign addr_ok = HSEL && HTRANS[1] && HREADY;

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (HADDR[7:0] == OSSR_FUSE_OFS) begin
      rdata_d[OSSR_FUSE_DIV_BIT:OSSR_FUSE_SEL_LSB] = fuse_q;
    end else if (HADDR[7:0] == OSSR_CTRL_OFS) begin
      rdata_d[OSSR_CTRL_BOD_EN_BIT] = bod_en;
    end else if (HADDR[7:0] == OSSR_STAT_OFS) begin
      rdata_d[OSSR_STAT_STATE_LSB +: 6] = state_q;
      rdata_d[OSSR_STAT_RANGE_LSB +: 3] = dec.range;
      rdata_d[OSSR_STAT_LOWPWR_BIT] = dec.low_power;
      rdata_d[OSSR_STAT_UNGUARD_BIT] = unguarded;
      rdata_d[OSSR_STAT_DIV_BIT] =
        (fuse_q.divide_by_eight_fuse == OSSR_FUSE_PROGRAMMED);
      rdata_d[OSSR_STAT_TOUT_LSB +: 2] = dec.tout;
    end else if (HADDR[7:0] == OSSR_CNT_OFS) begin
      rdata_d[15:0] = osc_count;
      rdata_d[OSSR_CNT_WDT_LSB +: 16] = wdt_count;
    end
    if (HADDR[31:8] != 24'h000000) begin
      rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
    end else if (CE) begin
      ready_q <= 1'b1;
      wr_pend_q <= addr_ok && HWRITE && HSIZE == 3'h2 &&
                   HADDR[31:8] == 24'h000000;
      if (addr_ok) begin
        wr_addr_q <= HADDR[7:0];
      end
      if (addr_ok && !HWRITE) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Control register; restart is a one-cycle self-clearing strobe.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= OSSR_CTRL_RESET;
      restart_q <= 1'b0;
    end else if (CE) begin
      restart_q <= 1'b0;
      if (wr_pend_q && wr_addr_q == OSSR_CTRL_OFS) begin
        ctrl_q[OSSR_CTRL_BOD_EN_BIT] <= HWDATA[OSSR_CTRL_BOD_EN_BIT];
        restart_q <= HWDATA[OSSR_CTRL_RESTART_BIT];
      end
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP = 1'b0;
  assign CORE_RESET_N = core_reset_n_q;
  assign CLOCK_STABLE = clock_stable_q;
  assign SYSCLK_EN = sysclk_en_q;
  assign FREQ_RANGE = range_q;

endmodule

// [ossr_pkg.sv]
package ossr_pkg;

  // Bus register map, byte addresses.
  localparam logic [7:0] OSSR_FUSE_OFS = 8'h00;
  localparam logic [7:0] OSSR_CTRL_OFS = 8'h04;
  localparam logic [7:0] OSSR_STAT_OFS = 8'h08;
  localparam logic [7:0] OSSR_CNT_OFS = 8'h0c;

  // Field positions.
  localparam int OSSR_FUSE_SEL_LSB = 0;
  localparam int OSSR_FUSE_SUT_LSB = 4;
  localparam int OSSR_FUSE_DIV_BIT = 6;
  localparam int OSSR_CTRL_RESTART_BIT = 0;
  localparam int OSSR_CTRL_BOD_EN_BIT = 1;
  localparam int OSSR_STAT_STATE_LSB = 0;
  localparam int OSSR_STAT_RANGE_LSB = 8;
  localparam int OSSR_STAT_LOWPWR_BIT = 11;
  localparam int OSSR_STAT_UNGUARD_BIT = 12;
  localparam int OSSR_STAT_DIV_BIT = 13;
  localparam int OSSR_STAT_TOUT_LSB = 16;
  localparam int OSSR_CNT_WDT_LSB = 16;

  // Reset values.
  localparam logic [1:0] OSSR_CTRL_RESET = 2'h0;
  localparam logic [2:0] OSSR_DIV_RESET = 3'h0;
  localparam logic [15:0] OSSR_CNT_RESET = 16'h0000;

  // Settling counts in oscillator cycles.
  localparam logic [15:0] OSSR_SETTLE_6 = 16'h0006;
  localparam logic [15:0] OSSR_SETTLE_258 = 16'h0102;
  localparam logic [15:0] OSSR_SETTLE_1K = 16'h0400;
  localparam logic [15:0] OSSR_SETTLE_16K = 16'h4000;
  localparam logic [15:0] OSSR_SETTLE_32K = 16'h8000;
  localparam logic [15:0] OSSR_FIXED_19 = 16'h0013;
  localparam logic [2:0] OSSR_DIV_LAST = 3'h7;

  // Supply time-out, counted in watchdog oscillator cycles.
  localparam int OSSR_WDT_KHZ = 128;
  localparam int OSSR_TOUT_SHORT_MS = 4;
  localparam int OSSR_TOUT_LONG_MS = 65;
  localparam int OSSR_TOUT_SHORT_CYC = OSSR_TOUT_SHORT_MS * OSSR_WDT_KHZ;
  localparam int OSSR_TOUT_LONG_CYC = OSSR_TOUT_LONG_MS * OSSR_WDT_KHZ;

  // Fuse polarity: 1 is unprogrammed, 0 is programmed.
  localparam logic OSSR_FUSE_PROGRAMMED = 1'b0;

  typedef enum logic [1:0] {
    OSSR_TOUT_NONE = 2'h0,
    OSSR_TOUT_SHORT = 2'h1,
    OSSR_TOUT_LONG = 2'h2
  } ossr_tout_t;

  typedef enum logic [5:0] {
    OSSR_S_HOLD = 6'h01,
    OSSR_S_TOUT = 6'h02,
    OSSR_S_FIX = 6'h04,
    OSSR_S_SETTLE = 6'h08,
    OSSR_S_RUN = 6'h10,
    OSSR_S_SLEEP = 6'h20
  } ossr_state_t;

  typedef struct packed {
    logic divide_by_eight_fuse;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } ossr_fuse_t;

  typedef struct packed {
    logic low_power;
    logic [2:0] range;
    logic [15:0] settle;
    ossr_tout_t tout;
  } ossr_decode_t;

endpackage

// [ossr_tick_counter.sv]
`timescale 1ns/1ps
module ossr_tick_counter import ossr_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [W-1:0] target,
  // Result
  output logic [W-1:0] count,
  output logic done
);

  logic [W-1:0] count_q;

  // The count saturates so that a long stall never wraps back below target.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (ce) begin
      if (clear) begin
        count_q <= '0;
      end else if (tick && count_q != {W{1'b1}}) begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  assign count = count_q;
  assign done = (count_q >= target);

endmodule

// [ossr_startup_sva.sv]
`timescale 1ns/1ps
module ossr_startup_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  // Bus answer
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Sequencer
  input wire logic RESET_SOURCES_RELEASED,
  input wire logic SLEEP_ENTER,
  input wire logic OSC_CLK,
  input wire logic CORE_RESET_N,
  input wire logic CLOCK_STABLE,
  input wire logic SYSCLK_EN,
  input wire logic [2:0] FREQ_RANGE
);
  logic osc_q;
  logic [15:0] osc_seen_q;

  // Counts every rising oscillator edge while the core is held, so it can only
  // be at or above what the sequencer itself counted.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_q <= 1'b0;
      osc_seen_q <= 16'h0000;
    end else begin
      osc_q <= OSC_CLK;
      if (CORE_RESET_N) begin
        osc_seen_q <= 16'h0000;
      end else if (OSC_CLK && !osc_q && osc_seen_q != 16'hffff) begin
        osc_seen_q <= osc_seen_q + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_src_hold; CE && !RESET_SOURCES_RELEASED |=> !CORE_RESET_N;
  endproperty
  a_src_hold: assert property (p_src_hold)
    else $error("core reset not held for reset source");
  property p_stable_run; CLOCK_STABLE |-> CORE_RESET_N; endproperty
  a_stable_run: assert property (p_stable_run)
    else $error("clock stable while core in reset");
  property p_release;
    $rose(CORE_RESET_N) |-> CLOCK_STABLE && osc_seen_q >= 16'h0019;
  endproperty
  a_release: assert property (p_release)
    else $error("core released before settling count");
  property p_range; CORE_RESET_N |-> $stable(FREQ_RANGE); endproperty
  a_range: assert property (p_range)
    else $error("frequency range changed while running");
  property p_div_pulse; SYSCLK_EN |=> !SYSCLK_EN; endproperty
  a_div_pulse: assert property (p_div_pulse)
    else $error("system clock enable longer than one cycle");
  property p_sleep;
    CE && CLOCK_STABLE && SLEEP_ENTER && RESET_SOURCES_RELEASED
      |=> CORE_RESET_N;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep entry reset the core");
  property p_ready; HREADYOUT |=> HREADYOUT; endproperty
  a_ready: assert property (p_ready)
    else $error("bus ready dropped");
  property p_okay; HRESP == 1'b0; endproperty
  a_okay: assert property (p_okay)
    else $error("bus response not okay");

  c_release: cover property ($rose(CORE_RESET_N));
  c_sleep: cover property (CLOCK_STABLE && SLEEP_ENTER);
  c_wake: cover property ($rose(CLOCK_STABLE) && $past(CORE_RESET_N));
endmodule

bind ossr_startup_top ossr_startup_sva u_sva (
  .CLK(CLK), .RSTN(RSTN), .CE(CE), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .RESET_SOURCES_RELEASED(RESET_SOURCES_RELEASED),
  .SLEEP_ENTER(SLEEP_ENTER), .OSC_CLK(OSC_CLK),
  .CORE_RESET_N(CORE_RESET_N), .CLOCK_STABLE(CLOCK_STABLE),
  .SYSCLK_EN(SYSCLK_EN), .FREQ_RANGE(FREQ_RANGE)
);

// [ossr_startup_tb.sv]
`timescale 1ns/1ps
module testbench;
  import ossr_pkg::*;
  // The long time-out is shortened so a run stays brief.
  localparam int LONG = 40;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hrdy, hresp, crn, cst, sen;
  logic [2:0] rng;
  ossr_fuse_t fuse = 7'h7f;
  logic rsr = 1'b1, brownout_detector = 1'b0, slp = 1'b0, wake = 1'b0;
  logic osc = 1'b0, wdt = 1'b0;
  int mismatches = 0;
  int samples_checked = 0;
  int sys_cnt = 0;

  ossr_startup_top #(.TOUT_LONG_CYC(LONG)) u_ossr_startup_top (
    .CLK(clk), .RSTN(rstn), .CE(1'b1), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
    .CLOCK_SOURCE_SELECT_FUSES(fuse.clock_source_select_fuses),
    .STARTUP_TIME_FUSES(fuse.startup_time_fuses),
    .DIVIDE_BY_EIGHT_FUSE(fuse.divide_by_eight_fuse),
    .RESET_SOURCES_RELEASED(rsr), .BROWNOUT_DETECTOR_OK(brownout_detector),
    .SLEEP_ENTER(slp), .WAKE_UP(wake), .OSC_CLK(osc), .WDT_OSC_CLK(wdt),
    .CORE_RESET_N(crn), .CLOCK_STABLE(cst), .SYSCLK_EN(sen),
    .FREQ_RANGE(rng)
  );

  always #25 clk = ~clk;
  always @(posedge clk) if (sen === 1'b1) sys_cnt++;

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits on ready without a limit; only the watchdog ends a hung wait.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  // Pulses are spaced so no edge lands on a counter's clearing edge.
  task automatic pulse(input logic w, input int n);
    repeat (n) begin
      if (w) wdt <= 1'b1;
      else osc <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      osc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic restart(input logic [6:0] f);
    fuse <= f;
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic seq(input int nw, input int no);
    logic [31:0] r;
    if (nw > 0) begin
      pulse(1'b1, nw - 1);
      bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
      check("state", 32'h02, {26'h0, r[5:0]});
      bus(1'b0, OSSR_CNT_OFS, 32'h0, r);
      check("wdt count", nw - 1, {16'h0, r[31:16]});
    end
    pulse(1'b1, 1);
    bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
    check("state", 32'h04, {26'h0, r[5:0]});
    pulse(1'b0, no - 1);
    check("core reset", 32'h0, {31'h0, crn});
    pulse(1'b0, 1);
    check("core run", 32'h3, {30'h0, crn, cst});
  endtask

  task automatic t_boots;
    logic [6:0] f[5] = '{7'h40, 7'h22, 7'h4a, 7'h68, 7'h44};
    int nw[5] = '{0, LONG, OSSR_TOUT_SHORT_CYC, 0, 0};
    // The 258-cycle entry models a resonator, not a crystal.
    int no[5] = '{25, 25, 277, 1043, 1043};
    for (int i = 0; i < 5; i++) begin
      restart(f[i]);
      check("range", {29'h0, f[i][3:1]}, {29'h0, rng});
      seq(nw[i], no[i]);
      sys_cnt = 0;
      pulse(1'b0, 16);
      check("sysclk", f[i][6] ? 32'h10 : 32'h2, sys_cnt);
    end
    $display("test boots done");
  endtask

  task automatic t_decode;
    logic [1:0] kind[8] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    logic [31:0] r, e, g;
    for (int k = 0; k < 8; k++) begin
      restart({1'b1, k[1:0], 3'h7, k[2]});
      bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
      e = {26'h0, kind[k], 4'hf};
      g = {26'h0, r[17:16], r[11:8]};
      check("decode", e, g);
    end
    $display("test decode done");
  endtask

  task automatic t_sleep;
    logic [31:0] r;
    restart(7'h42);
    seq(0, 25);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    repeat (2) @(posedge clk);
    bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
    check("sleep", 32'h20, {26'h0, r[5:0]});
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (2) @(posedge clk);
    pulse(1'b0, 5);
    check("wake hold", 32'h2, {30'h0, crn, cst});
    pulse(1'b0, 1);
    check("wake", 32'h3, {30'h0, crn, cst});
    rsr <= 1'b0;
    @(posedge clk);
    rsr <= 1'b1;
    repeat (2) @(posedge clk);
    check("held", 32'h0, {31'h0, crn});
    seq(0, 25);
    $display("test sleep done");
  endtask

  task automatic t_bod;
    logic [31:0] r;
    bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
    check("unguarded", 32'h1, {31'h0, r[12]});
    bus(1'b0, OSSR_FUSE_OFS, 32'h0, r);
    check("fuse", 32'h42, r);
    bus(1'b1, OSSR_FUSE_OFS, 32'h02, r);
    bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
    check("divide", 32'h1, {31'h0, r[13]});
    bus(1'b1, OSSR_CTRL_OFS, 32'h3, r);
    repeat (8) @(posedge clk);
    bus(1'b0, OSSR_CTRL_OFS, 32'h0, r);
    check("ctrl", 32'h2, r);
    bus(1'b0, OSSR_STAT_OFS, 32'h0, r);
    check("bod wait", 32'h02, {26'h0, r[5:0]});
    brownout_detector <= 1'b1;
    seq(0, 25);
    bus(1'b0, 8'h10, 32'h0, r);
    check("unmapped", 32'h0, r);
    $display("test brownout done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_boots();
    t_decode();
    t_sleep();
    t_bod();
    results();
  end

  // The tests need some thirteen thousand cycles; this allows three times.
  initial begin
    #2000000;
    mismatches++;
    results();
  end
endmodule
